// File: pkg/scr_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * converter control block. Assumes a 50 MHz hclk; included by bare name.
 */
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

`define SCR_CLK_NS        20
`define SCR_WIDTH         16
`define SCR_STEPS         16
`define SCR_FBR_NS        400
`define SCR_FBR_CYC       ((`SCR_FBR_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_DL_NS         60
`define SCR_DL_CYC        ((`SCR_DL_NS / `SCR_CLK_NS) < 1 ? 1 : (`SCR_DL_NS / `SCR_CLK_NS))
`define SCR_CYC_MAX_NS    10000
`define SCR_CYC_MAX       (`SCR_CYC_MAX_NS / `SCR_CLK_NS)
`define SCR_STRAP_CYC     4

`define SCR_OFF_CTRL      8'h00
`define SCR_OFF_STATUS    8'h04
`define SCR_OFF_RESULT    8'h08
`define SCR_OFF_COUNT     8'h0C

`define SCR_CTRL_LVDS     0
`define SCR_ST_BUSY       0
`define SCR_ST_READY      1
`define SCR_ST_PDOWN      2
`define SCR_ST_SELF       3
`define SCR_ST_VALID      4
`define SCR_ST_STRAP      5

`define SCR_CTRL_RESET    1'b0
`define SCR_HDR_SELF      3'h2
`define SCR_HDR_ECHO      3'h0

`endif

// File: pkg/scr_pkg.sv
/*
 * Types of the converter control block: state encoding and the packed
 * state record. Assumes scr_map.svh for numeric constants.
 */
package scr_pkg;

    typedef enum logic [4:0] {
        SCR_ACQ     = 5'h01,
        SCR_OPEN_SW = 5'h02,
        SCR_ARR_GND = 5'h04,
        SCR_STEP    = 5'h08,
        SCR_DONE    = 5'h10
    } scr_fsm_t;

    typedef struct packed {
        logic [2:0]  clk_s;
        logic [2:0]  cnv_s;
        logic [2:0]  lo_s;
        logic [2:0]  hi_s;
        logic [2:0]  echo_s;
        logic        clk_lvl;
        logic        cnv_lvl;
        logic        sel_lo;
        logic        sel_hi;
        scr_fsm_t    fsm;
        logic [3:0]  step;
        logic [15:0] trial;
        logic [15:0] sar;
        logic [15:0] result;
        logic [18:0] shifter;
        logic [7:0]  fbr_cnt;
        logic        fbr_run;
        logic [7:0]  dl_cnt;
        logic        dl_run;
        logic        ready;
        logic        pend_valid;
        logic        self_mode;
        logic [2:0]  strap_cnt;
        logic        strap_done;
        logic        first_done;
        logic        valid;
        logic [15:0] gap_cnt;
        logic        lvds_sel;
        logic        a_valid;
        logic        a_write;
        logic [7:0]  a_addr;
        logic [31:0] hrdata;
        logic [15:0] conv_count;
        logic        power_down;
        logic        ser_data;
        logic        echo_out;
        logic        echo_oe;
        logic        sw_p;
        logic        sw_n;
        logic        arr_gnd;
    } scr_state_t;

endpackage

// File: rtl/scr_core.sv
/*
 * Successive-approximation control and serial result readout, with an
 * AHB-Lite register slave. Assumes the analog comparator output is
 * synchronous to hclk and the echo pin has a pull-up unless strapped low.
 */
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_core (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        conv_start_p,
    input  wire logic        conv_start_n,
    input  wire logic        ser_clk,
    output logic             ser_data,
    input  wire logic        echo_clock_in,
    output logic             echo_clock_out,
    output logic             echo_clock_oe,
    input  wire logic        ref_mode_sel_lo,
    input  wire logic        ref_mode_sel_hi,
    input  wire logic        comp_keep,
    output logic      [15:0] dac_bits,
    output logic             sample_gnd_switch_p,
    output logic             sample_gnd_switch_n,
    output logic             array_to_gnd,
    output logic             power_down
);

    scr_pkg::scr_state_t st;
    scr_pkg::scr_state_t nx;
    logic                raw_start;
    logic                start_rise;
    logic                clk_fall;
    logic                take;

    // pair decode ahead of the synchroniser; a common-mode glitch gives no start edge
    assign raw_start = st.lvds_sel ? (conv_start_p & ~conv_start_n) : conv_start_p;
    assign take      = hsel & htrans[1] & hready;

    always_comb begin
        nx         = st;
        start_rise = 1'b0;
        clk_fall   = 1'b0;
        // three-stage pin synchronisers; level moves once stages two and three agree
        nx.clk_s   = {st.clk_s[1:0], ser_clk};
        nx.cnv_s   = {st.cnv_s[1:0], raw_start};
        nx.lo_s    = {st.lo_s[1:0], ref_mode_sel_lo};
        nx.hi_s    = {st.hi_s[1:0], ref_mode_sel_hi};
        nx.echo_s  = {st.echo_s[1:0], echo_clock_in};
        if (st.clk_s[1] == st.clk_s[2]) begin
            nx.clk_lvl = st.clk_s[2];
        end
        if (st.cnv_s[1] == st.cnv_s[2]) begin
            nx.cnv_lvl = st.cnv_s[2];
        end
        if (st.lo_s[1] == st.lo_s[2]) begin
            nx.sel_lo = st.lo_s[2];
        end
        if (st.hi_s[1] == st.hi_s[2]) begin
            nx.sel_hi = st.hi_s[2];
        end
        start_rise    = nx.cnv_lvl & ~st.cnv_lvl;
        clk_fall      = ~nx.clk_lvl & st.clk_lvl;
        nx.power_down = ~nx.sel_lo & ~nx.sel_hi;

        // mode strap: echo pin released after reset, then sampled once
        if (!st.strap_done) begin
            if (st.strap_cnt == 3'(`SCR_STRAP_CYC)) begin
                if (st.echo_s[1] == st.echo_s[2]) begin
                    nx.strap_done = 1'b1;
                    nx.self_mode  = ~st.echo_s[2];
                    nx.echo_oe    = st.echo_s[2];
                end
            end else begin
                nx.strap_cnt = st.strap_cnt + 3'h1;
            end
        end

        if (st.gap_cnt != 16'hFFFF) begin
            nx.gap_cnt = st.gap_cnt + 16'h0001;
        end

        // conversion sequencer, one comparator decision per clock
        case (st.fsm)
            scr_pkg::SCR_ACQ: begin
                nx.sw_p    = 1'b0;
                nx.sw_n    = 1'b0;
                nx.arr_gnd = 1'b0;
                if (start_rise && st.strap_done && !st.power_down) begin
                    nx.fsm        = scr_pkg::SCR_OPEN_SW;
                    nx.sw_p       = 1'b1;
                    nx.sw_n       = 1'b1;
                    nx.fbr_cnt    = 8'h00;
                    nx.fbr_run    = 1'b1;
                    nx.dl_cnt     = 8'h00;
                    nx.dl_run     = 1'b1;
                    nx.pend_valid = st.first_done && (st.gap_cnt <= 16'(`SCR_CYC_MAX));
                    nx.first_done = 1'b1;
                    nx.gap_cnt    = 16'h0000;
                end
            end
            scr_pkg::SCR_OPEN_SW: begin
                nx.fsm     = scr_pkg::SCR_ARR_GND;
                nx.arr_gnd = 1'b1;
                nx.sar     = 16'h0000;
                nx.trial   = 16'h8000;
                nx.step    = 4'h0;
            end
            scr_pkg::SCR_ARR_GND: begin
                nx.fsm = scr_pkg::SCR_STEP;
            end
            scr_pkg::SCR_STEP: begin
                // keep the trial bit when the comparator says the input is above it
                nx.sar   = comp_keep ? st.trial : st.sar;
                nx.trial = (comp_keep ? st.trial : st.sar) | (16'h4000 >> st.step);
                nx.step  = st.step + 4'h1;
                if (st.step == 4'(`SCR_STEPS - 1)) begin
                    nx.fsm = scr_pkg::SCR_DONE;
                end
            end
            scr_pkg::SCR_DONE: begin
                nx.result     = {~st.sar[15], st.sar[14:0]};
                nx.conv_count = st.conv_count + 16'h0001;
                nx.fsm        = scr_pkg::SCR_ACQ;
            end
            default: begin
                nx.fsm = scr_pkg::SCR_ACQ;
            end
        endcase

        // readout deadline of the previous word, counted from this start
        if (st.dl_run) begin
            nx.dl_cnt = st.dl_cnt + 8'h01;
            if (st.dl_cnt == 8'(`SCR_DL_CYC - 1)) begin
                nx.dl_run  = 1'b0;
                nx.ready   = 1'b0;
                nx.shifter = 19'h00000;
            end
        end

        // first-bit-ready time; sequencer always finishes inside it
        if (st.fbr_run) begin
            nx.fbr_cnt = st.fbr_cnt + 8'h01;
            if (st.fbr_cnt == 8'(`SCR_FBR_CYC - 1)) begin
                nx.fbr_run = 1'b0;
                nx.ready   = 1'b1;
                nx.valid   = st.pend_valid;
                nx.shifter = st.self_mode ? {`SCR_HDR_SELF, st.result} : {st.result, `SCR_HDR_ECHO};
            end
        end else if (st.ready && clk_fall) begin
            nx.shifter = {st.shifter[17:0], 1'b0};
        end

        nx.ser_data = nx.ready & nx.shifter[18];
        nx.echo_out = nx.ready & nx.clk_lvl & ~nx.self_mode;

        // bus slave: address phase latched, zero wait states
        nx.a_valid = take;
        nx.a_write = hwrite;
        nx.a_addr  = haddr[7:0];
        if (st.a_valid && st.a_write && st.a_addr == `SCR_OFF_CTRL) begin
            nx.lvds_sel = hwdata[`SCR_CTRL_LVDS];
        end
        nx.hrdata = 32'h00000000;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `SCR_OFF_CTRL: begin
                    nx.hrdata[`SCR_CTRL_LVDS] = nx.lvds_sel;
                end
                `SCR_OFF_STATUS: begin
                    nx.hrdata[`SCR_ST_BUSY]  = st.fsm != scr_pkg::SCR_ACQ;
                    nx.hrdata[`SCR_ST_READY] = st.ready;
                    nx.hrdata[`SCR_ST_PDOWN] = st.power_down;
                    nx.hrdata[`SCR_ST_SELF]  = st.self_mode;
                    nx.hrdata[`SCR_ST_VALID] = st.valid;
                    nx.hrdata[`SCR_ST_STRAP] = st.strap_done;
                end
                `SCR_OFF_RESULT: begin
                    nx.hrdata[15:0] = st.result;
                end
                `SCR_OFF_COUNT: begin
                    nx.hrdata[15:0] = st.conv_count;
                end
                default: begin
                    nx.hrdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.fsm      <= scr_pkg::SCR_ACQ;
            st.lvds_sel <= `SCR_CTRL_RESET;
            st.sel_lo   <= 1'b1;
            st.sel_hi   <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign hrdata              = st.hrdata;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign ser_data            = st.ser_data;
    assign echo_clock_out      = st.echo_out;
    assign echo_clock_oe       = st.echo_oe;
    assign dac_bits            = st.trial;
    assign sample_gnd_switch_p = st.sw_p;
    assign sample_gnd_switch_n = st.sw_n;
    assign array_to_gnd        = st.arr_gnd;
    assign power_down          = st.power_down;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_open;
        st.fsm == scr_pkg::SCR_OPEN_SW && st.sw_p && st.sw_n && !st.arr_gnd;
    endsequence
    sequence s_to_gnd;
        st.fsm == scr_pkg::SCR_ARR_GND && st.sw_p && st.arr_gnd;
    endsequence

    a_switch_order: assert property (s_open |=> s_to_gnd)
        else $error("arrays grounded before ground switches opened");
    a_start_gate: assert property ($rose(st.sw_p) |-> $past(st.strap_done) && !$past(st.power_down))
        else $error("conversion left acquisition without a valid start");
    a_start_ignored: assert property (st.fsm != scr_pkg::SCR_ACQ |=> !$rose(st.fbr_run))
        else $error("start accepted during conversion");
    a_sar_length: assert property ($rose(st.arr_gnd) |-> ##17 st.fsm == scr_pkg::SCR_DONE)
        else $error("approximation did not take sixteen steps");
    // old word holds until the deadline, so the low stretch starts three cycles in
    a_ready_time: assert property ($rose(st.fbr_run) |-> ##3 !st.ready ##17 st.ready)
        else $error("result ready at wrong time");
    a_ready_hold: assert property (st.fbr_run && st.fbr_cnt >= 8'h03 |-> !st.ready)
        else $error("result ready before first-bit-ready time");
    a_shift_fall: assert property (st.ready && !st.fbr_run && !st.dl_run && $fell(st.clk_lvl)
                                   |-> st.shifter == {$past(st.shifter[17:0]), 1'b0})
        else $error("shift not tied to falling serial clock");
    a_echo_copy: assert property (st.ready && !st.self_mode |-> st.echo_out == st.clk_lvl)
        else $error("echo clock does not follow serial clock");
    a_self_quiet: assert property (st.self_mode |-> !st.echo_out && !st.echo_oe)
        else $error("echo clock driven in self-clocked mode");
    a_header_zero: assert property (st.self_mode && $rose(st.ready) |-> !st.ser_data && st.shifter[17])
        else $error("self-clocked header wrong");
    a_twos_code: assert property (st.fsm == scr_pkg::SCR_DONE |=> st.result[15] != $past(st.sar[15]))
        else $error("result not in twos complement");
    a_power_down: assert property (!st.sel_lo && !st.sel_hi |-> st.power_down)
        else $error("power-down not entered");
    a_first_invalid: assert property ($rose(st.first_done) |-> !st.pend_valid)
        else $error("first result marked valid");

endmodule

// File: verif/scr_host.sv
/*
 * Host-side partner: bursts the serial clock and captures the result bits.
 * Assumes the bench raises go only after the device reports ready.
 */
`timescale 1ns/1ps
module scr_host (
    input  wire logic        go,
    input  wire logic [4:0]  nbits,
    input  wire logic        ser_data,
    output logic             ser_clk,
    output logic      [18:0] cap,
    output logic             done
);
    initial begin
        ser_clk = 1'b0;
        cap = 19'h00000;
        done = 1'b0;
        forever begin
            @(posedge go);
            done = 1'b0;
            repeat (nbits) begin
                ser_clk = 1'b1;
                // mid-high capture: device data lags the clock through its sync
                #40 cap = {cap[17:0], ser_data};
                #40 ser_clk = 1'b0;
                #80;
            end
            done = 1'b1;
        end
    end
endmodule

// File: verif/tb.sv
/*
 * Testbench of the converter control block: bus tasks, host partner, comparator.
 * Assumes scr_map.svh offsets and a zero-wait register slave.
 */
`timescale 1ns/1ps
`include "scr_map.svh"
module tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, start_p, start_n, ser_clk, ser_data;
    logic        echo_out, echo_oe, sel_lo, sel_hi, strap_lvl, comp_keep, sw_p, sw_n, arr_gnd, pdown;
    logic        go, done, arr_q, echo_q;
    int          echo_rise = 0;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] dac_bits, target;
    logic [18:0] cap;
    logic [4:0]  nbits;
    logic [15:0] codes [5] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000, 16'h1234};
    int          err_total = 0, tests_run = 0, cycles = 0, n_conv = 0;
    wire         echo_pin = echo_oe ? echo_out : strap_lvl;

    // offset-binary trial compare stands in for the analog comparator
    assign comp_keep = (target ^ 16'h8000) >= dac_bits;

    scr_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_start_p(start_p), .conv_start_n(start_n),
        .ser_clk(ser_clk), .ser_data(ser_data), .echo_clock_in(echo_pin), .echo_clock_out(echo_out),
        .echo_clock_oe(echo_oe), .ref_mode_sel_lo(sel_lo), .ref_mode_sel_hi(sel_hi),
        .comp_keep(comp_keep), .dac_bits(dac_bits), .sample_gnd_switch_p(sw_p),
        .sample_gnd_switch_n(sw_n), .array_to_gnd(arr_gnd), .power_down(pdown));
    scr_host i_host (.go(go), .nbits(nbits), .ser_data(ser_data), .ser_clk(ser_clk), .cap(cap), .done(done));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task summarize();
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge hclk) begin
        cycles++;
        arr_q <= arr_gnd;
        echo_q <= echo_out;
        if (echo_out === 1'b1 && echo_q === 1'b0) echo_rise++;
        if (arr_gnd === 1'b1 && arr_q === 1'b0) chk("gnd switches", 32'h1, {31'h0, sw_p & sw_n});
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // n level while p is high: low makes a valid pair, high a common-mode glitch
    task convert(input logic [15:0] code, input logic nlvl);
        @(posedge hclk);
        target <= code;
        start_p <= 1'b1;
        start_n <= nlvl;
        repeat (3) @(posedge hclk);
        start_p <= 1'b0;
        start_n <= 1'b1;
    endtask

    task wait_ready();
        for (int i = 0; i < 100; i++) begin
            ahb(1'b0, `SCR_OFF_STATUS, 32'h0);
            if (rd[`SCR_ST_READY] === 1'b1) break;
        end
    endtask

    task xfer(input logic [15:0] code, input logic self);
        convert(code, 1'b0);
        repeat (5) @(posedge hclk);
        ahb(1'b0, `SCR_OFF_STATUS, 32'h0);
        chk("early ready", 32'h0, {31'h0, rd[`SCR_ST_READY]});
        wait_ready();
        echo_rise = 0;
        nbits <= self ? 5'h13 : 5'h10;
        go <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge hclk);
            if (done === 1'b1) break;
        end
        go <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("echo pulses", self ? 32'h0 : 32'h10, echo_rise);
        chk("serial word", self ? {13'h0, 3'h2, code} : {16'h0, code}, self ? {13'h0, cap} : {16'h0, cap[15:0]});
        rd_chk(`SCR_OFF_RESULT, {16'h0, code}, "result");
        n_conv++;
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, start_p, go, arr_q} = '0;
        {start_n, sel_lo, sel_hi, strap_lvl} = 4'hF;
        target = 16'h0000;
        nbits = 5'h10;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        rd_chk(`SCR_OFF_STATUS, 32'h20, "status idle");
        chk("echo drive", 32'h1, {31'h0, echo_oe});
        rd_chk(32'h10, 32'h0, "unmapped");
        rd_chk(`SCR_OFF_CTRL, 32'h0, "ctrl reset");
        foreach (codes[i]) begin
            xfer(codes[i], 1'b0);
            ahb(1'b0, `SCR_OFF_STATUS, 32'h0);
            if (i < 2) chk("valid", {31'h0, i != 0}, {31'h0, rd[`SCR_ST_VALID]});
        end
        convert(16'h0100, 1'b0);
        repeat (4) @(posedge hclk);
        convert(16'h0200, 1'b0);
        wait_ready();
        n_conv++;
        rd_chk(`SCR_OFF_COUNT, n_conv, "count busy");
        sel_lo <= 1'b0;
        sel_hi <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("power down", 32'h1, {31'h0, pdown});
        convert(16'h0300, 1'b0);
        repeat (30) @(posedge hclk);
        rd_chk(`SCR_OFF_COUNT, n_conv, "count pdown");
        sel_lo <= 1'b1;
        sel_hi <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("power up", 32'h0, {31'h0, pdown});
        ahb(1'b1, `SCR_OFF_CTRL, 32'h1);
        rd_chk(`SCR_OFF_CTRL, 32'h1, "ctrl lvds");
        convert(16'h0400, 1'b1);
        repeat (30) @(posedge hclk);
        rd_chk(`SCR_OFF_COUNT, n_conv, "count common");
        xfer(16'h5A5A, 1'b0);
        rd_chk(`SCR_OFF_COUNT, n_conv, "count pair");
        hresetn <= 1'b0;
        strap_lvl <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        chk("echo quiet", 32'h0, {31'h0, echo_oe});
        rd_chk(`SCR_OFF_STATUS, 32'h28, "status self");
        xfer(16'hC3A5, 1'b1);
        xfer(16'h0001, 1'b1);
        summarize();
    end
endmodule
